// file: src/vsc_dev.sv
// Control word device: serial link end, word store and setting decode.
module vsc_dev
  import vsc_pkg::*;
(
  input  wire logic               clk,              // System clock.
  input  wire logic               arst_n,           // Asynchronous reset, active low.
  vsc_link_if.dev                 link,             // Serial link, device side.
  output      logic [15:0]        control_word,     // Current control word.
  output      vsc_pkg::vsc_filter_type filter_sel,  // Shared bandwidth limit.
  output      logic               aux_output_off,   // Auxiliary amplifier off.
  output      logic               preamp_high_gain, // Preamp at 30 dB.
  output      logic               preamp_low_gain,  // Preamp at 10 dB.
  output      logic [4:0]         ladder_atten_db,  // Attenuation in dB.
  output      logic               word_legal        // No reserved bit or bad code.
);
  import vsc_pkg::*;

  // Twice the ladder code gives the attenuation in dB.
  function automatic logic [4:0] ladder_to_db(input logic [3:0] code);
    ladder_to_db = {code, 1'b0};
  endfunction : ladder_to_db

  // True when a word holds only allowed codes and clear reserved bits.
  function automatic logic word_ok(input logic [15:0] w);
    logic [2:0] f;
    f       = w[FILTER_LSB +: FILTER_W];
    word_ok = ((w & RESERVED_MASK) == 16'h0000)
            && (w[LADDER_LSB +: LADDER_W] <= LADDER_MAX)
            && (f != VSC_BW_BAD);
  endfunction : word_ok

  // Link-side state, clocked by the link clock.
  logic        frame_idle;  // Select high or reset: clears the frame logic.
  logic [4:0]  edge_cnt;    // Rising edges seen in this frame.
  logic        rw_bit;      // Direction bit of this frame.
  logic [15:0] shift_reg;   // Incoming or outgoing bits.
  logic [15:0] shadow_word; // Completed write, held for the system side.
  logic        done_tgl;    // Flips once per completed write.
  logic        sdo;         // Device data out.
  logic        sdo_oe;      // Device drives the line.

  // System-side state.
  logic [1:0]  cs_sync;     // Select, two-stage synchroniser.
  logic [1:0]  done_sync;   // Done toggle, two-stage synchroniser.
  logic        done_seen;   // Last toggle value acted on.
  logic        pending;     // A finished write waits for the frame to close.
  logic        next_pending;
  logic        done_evt;
  logic        commit;
  logic [15:0] word_q;      // The stored control word.

  // The frame logic is held clear whenever select is high, so no link clock
  // edge is needed after a frame to tidy up.
  assign frame_idle = link.cs_n | ~arst_n;

  // Count edges up to a ceiling so that an over-long frame cannot wrap.
  always_ff @(posedge link.sclk or posedge frame_idle)
  begin
    if (frame_idle)
      edge_cnt <= 5'h00;
    else if (edge_cnt != EDGE_LAST)
      edge_cnt <= edge_cnt + 5'h01;
  end

  // The first bit of every frame says whether the host reads or writes.
  always_ff @(posedge link.sclk or posedge frame_idle)
  begin
    if (frame_idle)
      rw_bit <= 1'b0;
    else if (edge_cnt == 5'h00)
      rw_bit <= link.sdio;
  end

  // Shift register: samples data on writes, presents the word on reads.
  // On a read the stored word is sampled one edge after the direction bit;
  // it only changes while select is high, so it is steady here.
  always_ff @(posedge link.sclk or posedge frame_idle)
  begin
    if (frame_idle)
      shift_reg <= 16'h0000;
    else if (rw_bit == RW_READ)
    begin
      if (edge_cnt == 5'h01)
        shift_reg <= word_q;
      else if (edge_cnt < READ_EDGES - 5'h01)
        shift_reg <= {shift_reg[14:0], 1'b0};
    end
    else if (edge_cnt != 5'h00 && edge_cnt < WRITE_EDGES)
      shift_reg <= {shift_reg[14:0], link.sdio};
  end

  // Read data drive. The device turns the line around one edge after the
  // direction bit, which leaves the host half a period to let go of it.
  always_ff @(posedge link.sclk or posedge frame_idle)
  begin
    if (frame_idle)
    begin
      sdo_oe <= 1'b0;
      sdo    <= 1'b0;
    end
    else if (rw_bit == RW_READ && edge_cnt == 5'h01)
    begin
      sdo_oe <= 1'b1;
      sdo    <= word_q[15];
    end
    else if (rw_bit == RW_READ && edge_cnt < READ_EDGES - 5'h01)
      sdo    <= shift_reg[14];
  end

  assign link.dev_sdio_o  = sdo;
  assign link.dev_sdio_oe = sdo_oe;

  // A write is complete at the edge that takes its last bit; the word is
  // parked in a shadow and the system side is told by a toggle.
  always_ff @(posedge link.sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shadow_word <= WORD_RESET;
      done_tgl    <= 1'b0;
    end
    else if (!link.cs_n && rw_bit != RW_READ && edge_cnt == WRITE_EDGES - 5'h01)
    begin
      shadow_word <= {shift_reg[14:0], link.sdio};
      done_tgl    <= ~done_tgl;
    end
  end

  // Bring select and the done toggle into the system clock domain.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_sync   <= 2'b11;
      done_sync <= 2'b00;
      done_seen <= 1'b0;
    end
    else
    begin
      cs_sync   <= {cs_sync[0], link.cs_n};
      done_sync <= {done_sync[0], done_tgl};
      done_seen <= done_sync[1];
    end
  end

  // The new word waits until the frame is closed. A done event that lands
  // on the commit cycle still sets the flag.
  assign done_evt     = done_sync[1] ^ done_seen;
  assign commit       = pending & cs_sync[1];
  assign next_pending = done_evt | (pending & ~commit);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pending <= 1'b0;
    else
      pending <= next_pending;
  end

  // The stored word. The shadow is steady once its toggle has been seen.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      word_q <= WORD_RESET;
    else if (commit)
      word_q <= shadow_word;
  end

  // Decoded settings, registered so they change in one clean step.
  // A bad code is passed through as is; the analog side treats it as
  // undefined, and word_legal lets software see it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filter_sel       <= VSC_BW_FULL;
      aux_output_off   <= 1'b0;
      preamp_high_gain <= 1'b0;
      preamp_low_gain  <= 1'b1;
      ladder_atten_db  <= ladder_to_db(WORD_RESET[LADDER_LSB +: LADDER_W]);
      word_legal       <= 1'b1;
    end
    else
    begin
      filter_sel       <= vsc_filter_type'(word_q[FILTER_LSB +: FILTER_W]);
      aux_output_off   <= word_q[POWER_BIT];
      preamp_high_gain <= word_q[PREAMP_BIT];
      preamp_low_gain  <= ~word_q[PREAMP_BIT];
      ladder_atten_db  <= ladder_to_db(word_q[LADDER_LSB +: LADDER_W]);
      word_legal       <= word_ok(word_q);
    end
  end

  assign control_word = word_q;

endmodule : vsc_dev

// file: src/vsc_host.sv
// Host controller: APB registers driving the three-wire control link.
module vsc_host
  import vsc_pkg::*;
(
  input  wire logic        clk,     // System clock.
  input  wire logic        arst_n,  // Asynchronous reset, active low.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB access phase.
  input  wire logic        pwrite,  // APB write.
  input  wire logic [7:0]  paddr,   // APB byte address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output      logic [31:0] prdata,  // APB read data.
  output      logic        pready,  // APB ready.
  output      logic        pslverr, // APB error on unmapped address.
  vsc_link_if.host         link     // Serial link, host side.
);
  import vsc_pkg::*;

  typedef enum logic [1:0] {
    VSC_IDLE  = 2'b00,
    VSC_SHIFT = 2'b01,
    VSC_GAP   = 2'b10
  } vsc_state_type;

  vsc_state_type state;
  logic [15:0] tx_word;   // Word for the next write.
  logic [15:0] rx_word;   // Last word read back.
  logic        rx_ok;     // A read has completed.
  logic [16:0] tx_shift;  // Direction bit then word.
  logic        rd_mode;   // Current frame is a read.
  logic [4:0]  edges;     // Rising edges made in this frame.
  logic [7:0]  tick_cnt;  // Half period and gap timer.
  logic        cs_n;
  logic        sclk;
  logic        sdo_oe;
  logic [1:0]  sdi_sync;  // Line level, two-stage synchroniser.
  logic        wr_go;
  logic        rd_go;
  logic        mapped;
  logic        tick;

  // Every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign mapped  = paddr == REG_TXDATA || paddr == REG_CMD
                || paddr == REG_STATUS || paddr == REG_RXDATA;
  assign pslverr = psel & penable & ~mapped;
  assign wr_go   = psel & penable & pwrite & (paddr == REG_CMD) & pwdata[CMD_WRITE_BIT];
  assign rd_go   = psel & penable & pwrite & (paddr == REG_CMD) & pwdata[CMD_READ_BIT];

  // Word register. Reserved bits are forced to zero here, so software cannot
  // push the device into undefined operation through them.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_word <= WORD_RESET;
    else if (psel && penable && pwrite && paddr == REG_TXDATA)
      tx_word <= pwdata[15:0] & ~RESERVED_MASK;
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        REG_TXDATA: prdata <= {16'h0000, tx_word};
        REG_STATUS: prdata <= {30'h0, rx_ok, state != VSC_IDLE};
        REG_RXDATA: prdata <= {16'h0000, rx_word};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign tick = tick_cnt == 8'(HALF_CYC - 1);

  // Frame sequencer. The link clock is this clock divided by 2*HALF_CYC;
  // data changes on its falling half so each bit is steady around the rise.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= VSC_IDLE;
      cs_n     <= 1'b1;
      sclk     <= 1'b0;
      sdo_oe   <= 1'b0;
      tx_shift <= 17'h00000;
      rd_mode  <= 1'b0;
      edges    <= 5'h00;
      tick_cnt <= 8'h00;
    end
    else
    begin
      case (state)
        VSC_IDLE:
        begin
          // A command while busy, or a write of a disallowed code, is dropped.
          if ((wr_go && codes_ok(tx_word)) || (rd_go && !wr_go))
          begin
            state    <= VSC_SHIFT;
            cs_n     <= 1'b0;
            sdo_oe   <= 1'b1;
            rd_mode  <= rd_go & ~wr_go;
            tx_shift <= {rd_go & ~wr_go, tx_word};
            edges    <= 5'h00;
            tick_cnt <= 8'h00;
          end
        end
        VSC_SHIFT:
        begin
          tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
          if (tick && !sclk)
          begin
            if (edges == (rd_mode ? READ_EDGES : WRITE_EDGES))
            begin
              cs_n     <= 1'b1;
              sdo_oe   <= 1'b0;
              state    <= VSC_GAP;
            end
            else
            begin
              sclk  <= 1'b1;
              edges <= edges + 5'h01;
            end
          end
          else if (tick && sclk)
          begin
            sclk     <= 1'b0;
            tx_shift <= {tx_shift[15:0], 1'b0};
            if (rd_mode)
              sdo_oe <= 1'b0;
          end
        end
        VSC_GAP:
        begin
          tick_cnt <= tick_cnt + 8'h01;
          if (tick_cnt == 8'(GAP_CYC - 1))
            state  <= VSC_IDLE;
        end
        default: state <= VSC_IDLE;
      endcase
    end
  end

  // Read-back bits are taken at the rising edges three to eighteen.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdi_sync <= 2'b11;
      rx_word  <= 16'h0000;
      rx_ok    <= 1'b0;
    end
    else
    begin
      sdi_sync <= {sdi_sync[0], link.sdio};
      if (state == VSC_SHIFT && rd_mode && tick && !sclk && edges >= 5'h02 && edges < READ_EDGES)
        rx_word <= {rx_word[14:0], sdi_sync[1]};
      if (state == VSC_SHIFT && rd_mode && tick && !sclk && edges == READ_EDGES)
        rx_ok   <= 1'b1;
      else if (rd_go || wr_go)
        rx_ok   <= rx_ok & (state != VSC_IDLE);
    end
  end

  // True when the ladder and filter fields hold allowed codes only.
  function automatic logic codes_ok(input logic [15:0] w);
    codes_ok = (w[LADDER_LSB +: LADDER_W] <= LADDER_MAX)
            && (w[FILTER_LSB +: FILTER_W] != VSC_BW_BAD);
  endfunction : codes_ok

  assign link.cs_n         = cs_n;
  assign link.sclk         = sclk;
  assign link.host_sdio_o  = tx_shift[16];
  assign link.host_sdio_oe = sdo_oe;

endmodule : vsc_host

// file: src/vsc_link_if.sv
// Three-wire link between the host controller and the control word device.
interface vsc_link_if;

  logic cs_n;        // Frame select, low during an access.
  logic sclk;        // Link clock made by the host.
  logic host_sdio_o; // Host data out.
  logic host_sdio_oe;// Host drives the data line.
  logic dev_sdio_o;  // Device data out.
  logic dev_sdio_oe; // Device drives the data line.
  logic sdio;        // Resolved line level.

  // Whichever end enables its driver sets the line, the host if both do; a pull-up holds it otherwise.
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

  modport host (output cs_n, output sclk, output host_sdio_o, output host_sdio_oe, input sdio);
  modport dev  (input cs_n, input sclk, output dev_sdio_o, output dev_sdio_oe, input sdio);

endinterface : vsc_link_if

// file: src/vsc_pkg.sv
// Shared constants and types for the serial control word link.
package vsc_pkg;

  // Control word layout and power-on value.
  localparam int          WORD_W        = 16;
  localparam logic [15:0] WORD_RESET    = 16'h000A;
  localparam int          LADDER_LSB    = 0;
  localparam int          LADDER_W      = 4;
  localparam int          PREAMP_BIT    = 4;
  localparam int          FILTER_LSB    = 6;
  localparam int          FILTER_W      = 3;
  localparam int          POWER_BIT     = 10;
  localparam logic [15:0] RESERVED_MASK = 16'h7A20;
  localparam logic [3:0]  LADDER_MAX    = 4'hA;

  // Frame layout: one direction bit, then the word, most significant bit first.
  localparam logic        RW_READ     = 1'b1;
  localparam logic [4:0]  WRITE_EDGES = 5'h11;
  localparam logic [4:0]  READ_EDGES  = 5'h12;
  localparam logic [4:0]  EDGE_LAST   = 5'h1F;

  // Link timing, in nanoseconds and in system clock cycles.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCLK_MIN_NS    = 100;
  localparam int SETUP_NS       = 25;
  localparam int GAP_SCLK       = 3;
  localparam int HALF_CYC       = (SCLK_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC        = GAP_SCLK * 2 * HALF_CYC;

  // Host register map, byte addresses on APB.
  localparam logic [7:0] REG_TXDATA = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam int         CMD_WRITE_BIT  = 0;
  localparam int         CMD_READ_BIT   = 1;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_RXOK_BIT  = 1;

  // Bandwidth limit selections.
  typedef enum logic [2:0] {
    VSC_BW_FULL = 3'b000,
    VSC_BW_20   = 3'b001,
    VSC_BW_100  = 3'b010,
    VSC_BW_200  = 3'b011,
    VSC_BW_350  = 3'b100,
    VSC_BW_650  = 3'b101,
    VSC_BW_750  = 3'b110,
    VSC_BW_BAD  = 3'b111
  } vsc_filter_type;

endpackage : vsc_pkg

// file: tb/vga_serial_control_word_tb.sv
// Testbench: APB host driving the device end, plus a bench-driven link into a second device.
module vga_serial_control_word_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vsc_pkg::*;

  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] control_word, cw_b, w, model_word;
  vsc_filter_type filter_sel;
  logic aux_output_off, preamp_high_gain, preamp_low_gain, word_legal;
  logic [4:0] ladder_atten_db;
  int miscompares, comparisons, k;

  vsc_link_if la();
  vsc_link_if lb();

  vsc_host i_vsc_host (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(la));
  vsc_dev i_vsc_dev (.clk(clk), .arst_n(arst_n), .link(la), .control_word(control_word),
    .filter_sel(filter_sel), .aux_output_off(aux_output_off), .preamp_high_gain(preamp_high_gain),
    .preamp_low_gain(preamp_low_gain), .ladder_atten_db(ladder_atten_db), .word_legal(word_legal));
  // Second device, fed by the bench so frames can be cut short on purpose.
  vsc_dev i_vsc_dev_b (.clk(clk), .arst_n(arst_n), .link(lb), .control_word(cw_b), .filter_sel(),
    .aux_output_off(), .preamp_high_gain(), .preamp_low_gain(), .ladder_atten_db(), .word_legal());
  vsc_link_checker i_vsc_link_checker (.clk(clk), .arst_n(arst_n), .cs_n(la.cs_n), .sclk(la.sclk),
    .host_sdio_o(la.host_sdio_o), .host_sdio_oe(la.host_sdio_oe), .dev_sdio_o(la.dev_sdio_o),
    .dev_sdio_oe(la.dev_sdio_oe), .sdio(la.sdio));

  // 100 MHz system clock.
  always #5 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check(32'(e), 32'(exp_err));
  endtask : rd_chk

  // Busy is polled with a bound; a hung link ends the run.
  task automatic wait_idle();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, r, e);
      n++;
    end
    while (r[STAT_BUSY_BIT] !== 1'b0 && n < 400);
    if (r[STAT_BUSY_BIT] !== 1'b0)
    begin
      miscompares++;
      conclude();
    end
  endtask : wait_idle

  // Waits for the word to land, then compares every decoded setting.
  task automatic dev_chk(input logic [15:0] x);
    int n;
    n = 0;
    while (control_word !== x && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    check(32'(control_word), 32'(x));
    check(32'(filter_sel), 32'(x[8:6]));
    check(32'(aux_output_off), 32'(x[10]));
    check(32'({preamp_high_gain, preamp_low_gain}), 32'({x[4], ~x[4]}));
    check(32'(ladder_atten_db), 32'({x[3:0], 1'b0}));
    check(32'(word_legal), 32'((x & RESERVED_MASK) == 16'h0000 && x[3:0] <= LADDER_MAX && x[8:6] != 3'h7));
  endtask : dev_chk

  // The host clears reserved bits and drops writes of disallowed codes.
  task automatic link_write(input logic [15:0] x);
    wr(REG_TXDATA, {16'h0000, x});
    wr(REG_CMD, 32'h0000_0001);
    wait_idle();
    if (x[3:0] <= LADDER_MAX && x[8:6] != 3'h7)
      model_word = x & ~RESERVED_MASK;
    dev_chk(model_word);
  endtask : link_write

  task automatic link_read(input logic [15:0] x);
    wr(REG_CMD, 32'h0000_0002);
    wait_idle();
    rd_chk(REG_RXDATA, {16'h0000, x}, 1'b0);
    rd_chk(REG_STATUS, 32'h0000_0002, 1'b0);
  endtask : link_read

  // Bench-made frame of n rises at an 80 ns link period; data changes on the falling edge.
  task automatic bang(input logic [16:0] f, input int n);
    int i;
    @(posedge clk);
    lb.cs_n <= 1'b0;
    lb.host_sdio_oe <= 1'b1;
    lb.host_sdio_o <= f[16];
    for (i = 0; i < n; i++)
    begin
      repeat (4) @(posedge clk);
      lb.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      lb.sclk <= 1'b0;
      lb.host_sdio_o <= (i < 16) ? f[15 - i] : 1'b0;
    end
    repeat (4) @(posedge clk);
    lb.cs_n <= 1'b1;
    lb.host_sdio_oe <= 1'b0;
    repeat (24) @(posedge clk);
  endtask : bang

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lb.cs_n = 1'b1;
    lb.sclk = 1'b0;
    lb.host_sdio_o = 1'b0;
    lb.host_sdio_oe = 1'b0;
    miscompares = 0;
    comparisons = 0;
    model_word = WORD_RESET;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    dev_chk(WORD_RESET);
    rd_chk(REG_STATUS, 32'h0000_0000, 1'b0);
    link_read(WORD_RESET);
    $display("test reset values done");
    // Every allowed filter code, every allowed ladder code, both gains and both power modes.
    for (k = 0; k < 11; k++)
    begin
      w = {5'h00, k[1], 1'b0, 3'(k % 7), 1'b0, k[0], 4'(k)};
      link_write(w);
      link_read(w);
    end
    $display("test settings sweep done");
    link_write(16'h01CB);
    link_write(16'h0020);
    wr(8'h10, 32'h0000_1234);
    rd_chk(8'h10, 32'h0000_0000, 1'b1);
    $display("test bad codes and unmapped access done");
    bang({1'b0, 16'h0456}, 9);
    check(32'(cw_b), 32'(WORD_RESET));
    bang({1'b0, 16'h0456}, 17);
    check(32'(cw_b), 32'h0000_0456);
    $display("test cut frame done");
    conclude();
  end

endmodule : vga_serial_control_word_tb

// file: tb/vsc_link_checker.sv
// Concurrent checks on the three-wire link between the host and the device ends.
module vsc_link_checker
  import vsc_pkg::*;
(
  input  wire logic clk,          // System clock.
  input  wire logic arst_n,       // Asynchronous reset, active low.
  input  wire logic cs_n,         // Frame select.
  input  wire logic sclk,         // Link clock.
  input  wire logic host_sdio_o,  // Host data bit.
  input  wire logic host_sdio_oe, // Host drive enable.
  input  wire logic dev_sdio_o,   // Device data bit.
  input  wire logic dev_sdio_oe,  // Device drive enable.
  input  wire logic sdio          // Resolved line level.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       sclk_q;
  logic [4:0] rise_cnt;
  logic       rw_q;
  logic [5:0] gap_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Rises are counted per frame and the direction bit is kept from the first rise.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q   <= 1'b0;
      rise_cnt <= 5'h00;
      rw_q     <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        rise_cnt <= 5'h00;
      else if (sclk && !sclk_q)
        rise_cnt <= rise_cnt + 5'h01;
      if (!cs_n && sclk && !sclk_q && rise_cnt == 5'h00)
        rw_q <= sdio;
    end
  end

  // Reset loads a full count, so the first frame is not judged against the reset period.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_cnt <= 6'h3F;
    else if (!cs_n)
      gap_cnt <= 6'h00;
    else if (gap_cnt != 6'h3F)
      gap_cnt <= gap_cnt + 6'h01;
  end

  AST_NO_CONTENTION: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data line");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  AST_DEV_IDLE: assert property (cs_n |-> !dev_sdio_oe)
    else $error("device drives the line outside a frame");
  AST_FRAME_START: assert property ($fell(cs_n) |-> host_sdio_oe && !sclk)
    else $error("frame opens without the host driving");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
    else $error("link clock high phase is not five cycles");
  AST_DATA_HOLD: assert property ($rose(sclk) && host_sdio_oe |-> $stable(host_sdio_o) ##1 $stable(host_sdio_o))
    else $error("host data moves around a rising link clock");
  AST_GAP: assert property ($fell(cs_n) |-> gap_cnt >= 6'(GAP_CYC))
    else $error("gap between frames too short");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> rise_cnt == ((rw_q == RW_READ) ? READ_EDGES : WRITE_EDGES))
    else $error("frame closed after a wrong number of rises");
  AST_DEV_TURN: assert property ($rose(dev_sdio_oe) |-> $rose(sclk) && rise_cnt == 5'h01 && rw_q == RW_READ)
    else $error("device starts driving at the wrong rise");
  AST_HOST_TURN: assert property (!cs_n && rw_q == RW_READ && rise_cnt >= 5'h02 |-> !host_sdio_oe)
    else $error("host still drives during read-back");
  AST_HOST_WRITE: assert property (!cs_n && rw_q != RW_READ && rise_cnt != 5'h00 && rise_cnt < WRITE_EDGES
                                   |-> host_sdio_oe)
    else $error("host released the line during a write");

  // Main scenarios: a write frame, a read frame, a device turnaround.
  COV_WRITE: cover property ($rose(cs_n) && rw_q != RW_READ);
  COV_READ: cover property ($rose(cs_n) && rw_q == RW_READ);
  COV_TURN: cover property ($rose(dev_sdio_oe));

endmodule : vsc_link_checker
